// ==== core/mtp_pkg.sv ====
package mtp_pkg;

    // register byte offsets on the axi4-lite port
    localparam logic [7:0] OFF_CTRL_A  = 8'h00;
    localparam logic [7:0] OFF_CTRL_B  = 8'h04;
    localparam logic [7:0] OFF_CTRL_CD = 8'h08;
    localparam logic [7:0] OFF_DATA_A  = 8'h0c;
    localparam logic [7:0] OFF_DATA_B  = 8'h10;
    localparam logic [7:0] OFF_DATA_C  = 8'h14;
    localparam logic [7:0] OFF_DATA_D  = 8'h18;
    localparam logic [7:0] OFF_EDGE    = 8'h1c;
    localparam logic [7:0] OFF_STATUS  = 8'h20;

    // control field layout
    localparam int         CTRL_OUT_RST_BIT = 4;      // output-reset strobe, reads zero
    localparam int         CTRL_D_LSB       = 4;      // timer d select in the c/d register
    localparam logic [3:0] MODE_STOP        = 4'h0;
    localparam logic [3:0] MODE_EVENT       = 4'h8;

    // edge polarity bits feeding the two auxiliary inputs
    localparam int EDGE_BIT_A = 4;
    localparam int EDGE_BIT_B = 3;

    // status layout: [3:0] timeouts, [5:4] io events, [7:6] live io levels
    localparam int STAT_IO_FOUR  = 4;
    localparam int STAT_IO_THREE = 5;
    localparam int STAT_LVL_FOUR = 6;
    localparam int STAT_LVL_THREE = 7;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] EDGE_RST = 8'h00;
    localparam logic [5:0] STAT_RST = 6'h00;

    // prescale division in timer clocks, indexed by the low three mode bits
    localparam logic [7:0] PRESCALE_DIV [8] = '{8'h01, 8'h04, 8'h0a, 8'h10, 8'h32, 8'h40, 8'h64, 8'hc8};
    localparam logic [7:0] PRESCALE_MAX     = 8'hc8;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // register selector
    typedef enum logic [3:0] {
        REG_CTRL_A  = 4'h0,
        REG_CTRL_B  = 4'h1,
        REG_CTRL_CD = 4'h2,
        REG_DATA_A  = 4'h3,
        REG_DATA_B  = 4'h4,
        REG_DATA_C  = 4'h5,
        REG_DATA_D  = 4'h6,
        REG_EDGE    = 4'h7,
        REG_STATUS  = 4'h8,
        REG_NONE    = 4'hf
    } mtp_reg_t;

    // address decode shared by the read and write paths
    function automatic mtp_reg_t mtp_decode(input logic [7:0] addr);
        if (addr == OFF_CTRL_A) return REG_CTRL_A;
        else if (addr == OFF_CTRL_B) return REG_CTRL_B;
        else if (addr == OFF_CTRL_CD) return REG_CTRL_CD;
        else if (addr == OFF_DATA_A) return REG_DATA_A;
        else if (addr == OFF_DATA_B) return REG_DATA_B;
        else if (addr == OFF_DATA_C) return REG_DATA_C;
        else if (addr == OFF_DATA_D) return REG_DATA_D;
        else if (addr == OFF_EDGE) return REG_EDGE;
        else if (addr == OFF_STATUS) return REG_STATUS;
        else return REG_NONE;
    endfunction : mtp_decode

endpackage : mtp_pkg

// ==== core/mtp_chan_if.sv ====
`timescale 1ns/1ps
// control and result of one timer channel
interface mtp_chan_if;
    logic [3:0] mode;         // mode field of the owning control register
    logic       gate;         // auxiliary input is at its active level
    logic       event_pulse;  // one active transition of the auxiliary input
    logic       data_we;      // host writes the data register
    logic [7:0] data_wval;    // value being written
    logic [7:0] count;        // live main counter
    logic       timeout;      // one-cycle timeout pulse

    modport ctrl (output mode, gate, event_pulse, data_we, data_wval, input count, timeout);
    modport chan (input mode, gate, event_pulse, data_we, data_wval, output count, timeout);
endinterface : mtp_chan_if

// ==== core/mtp_timer_chan.sv ====
`timescale 1ns/1ps
// one timer: prescaler, 8-bit down counter, reload constant
module mtp_timer_chan #(
    parameter bit MULTI = 1'b1   // pulse width and event count allowed
) (
    input wire logic aclk,
    input wire logic aresetn,
    mtp_chan_if.chan bus
);

    logic [7:0] data_reg;     // time constant, never reset
    logic [7:0] cnt_reg;      // main counter, never reset
    logic [7:0] ps_reg;       // prescaler position
    logic       timeout_reg;  // timeout pulse
    logic [3:0] mode_eff;     // mode after stripping unsupported codes
    logic       running;
    logic       is_evt;
    logic       is_pw;
    logic       ps_run;
    logic       ps_tick;
    logic       count_pulse;
    logic [7:0] div;

    // timers without the aux modes only see stopped or delay
    always_comb begin
        mode_eff    = MULTI ? bus.mode : {1'b0, bus.mode[2:0]};
        running     = mode_eff != mtp_pkg::MODE_STOP;
        is_evt      = mode_eff == mtp_pkg::MODE_EVENT;
        is_pw       = mode_eff[3] && (mode_eff[2:0] != 3'h0);
        div         = mtp_pkg::PRESCALE_DIV[mode_eff[2:0]];
        // prescaler halts while the pulse gate is inactive
        ps_run      = (running && !mode_eff[3]) || (is_pw && bus.gate);
        // compare with >= so a smaller prescale mid-count still wraps at once
        ps_tick     = ps_run && (ps_reg >= div - 8'h01);
        // event mode bypasses the prescaler
        count_pulse = is_evt ? bus.event_pulse : ps_tick;
    end

    // prescaler: cleared when stopped, held when gated off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ps_reg <= 8'h00;
        end else if (!running) begin
            ps_reg <= 8'h00;
        end else if (ps_run) begin
            ps_reg <= ps_tick ? 8'h00 : ps_reg + 8'h01;
        end
    end

    // time constant keeps its value across reset
    always_ff @(posedge aclk) begin
        if (bus.data_we) begin
            data_reg <= bus.data_wval;
        end
    end

    // main counter: load when stopped, else only reload through one
    always_ff @(posedge aclk) begin
        if (bus.data_we && !running) begin
            cnt_reg <= bus.data_wval;
        end else if (count_pulse) begin
            cnt_reg <= (cnt_reg == 8'h01) ? data_reg : cnt_reg - 8'h01;
        end
    end

    // timeout on the pulse that would have reached zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timeout_reg <= 1'b0;
        end else begin
            timeout_reg <= count_pulse && (cnt_reg == 8'h01);
        end
    end

    assign bus.count   = cnt_reg;
    assign bus.timeout = timeout_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_reload_at_one: assert property (count_pulse && cnt_reg == 8'h01 && !bus.data_we |=>
        timeout_reg && cnt_reg == $past(data_reg)) else $error("reload through one failed");
    chk_decrement_step: assert property (count_pulse && cnt_reg != 8'h01 && !bus.data_we |=>
        !timeout_reg && cnt_reg == $past(cnt_reg) - 8'h01) else $error("counter did not step down");
    chk_pulse_gate_halt: assert property (is_pw && !bus.gate && !bus.data_we |=>
        $stable(ps_reg) && $stable(cnt_reg)) else $error("timer ran with gate inactive");
    chk_running_write_deferred: assert property (running && bus.data_we && !count_pulse |=>
        $stable(cnt_reg)) else $error("running write reached the counter");
    chk_prescale_bound: assert property (ps_reg < mtp_pkg::PRESCALE_MAX)
        else $error("prescaler beyond largest division");

endmodule : mtp_timer_chan

// ==== core/mtp_timer_top.sv ====
`timescale 1ns/1ps
module mtp_timer_top #(
    parameter int ADDR_W = 8   // axi address width
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              aux_input_a,
    input  wire logic              aux_input_b,
    input  wire logic              io_line_three,
    input  wire logic              io_line_four,
    output logic [3:0]             timer_out
);

    // bus slave state
    logic                 awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0]           bresp_reg, rresp_reg;
    logic [31:0]          rdata_reg;
    logic                 aw_got_reg, w_got_reg;      // halves of a write already taken
    logic [ADDR_W-1:0]    awaddr_reg;
    logic [7:0]           wdata_reg;
    logic                 wstrb0_reg;
    logic                 wr_fire;                    // write commits this cycle
    mtp_pkg::mtp_reg_t    wr_sel, rd_sel;

    // programmable registers
    logic [7:0]           ctrl_a_reg, ctrl_b_reg, ctrl_cd_reg;
    logic [7:0]           edge_polarity_reg;
    logic [5:0]           status_reg;                 // sticky events
    logic [3:0]           timer_out_reg;

    // input conditioning: index 0 aux a, 1 aux b, 2 line three, 3 line four
    logic [3:0]           s1_reg, s2_reg, s3_reg, filt_reg;

    // per multimode timer
    logic [1:0]           pw_mode, evt_mode, edge_bit, act, act_prev_reg;
    logic [1:0]           chan_lvl, chan_prev_reg, io_event, force_low;
    logic [3:0]           chan_mode [4];
    logic [7:0]           chan_count [4];
    logic [3:0]           timeouts;

    mtp_chan_if chan_bus [4] ();

    // write half handshakes, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= mtp_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready_reg) begin
                aw_got_reg  <= 1'b1;
                awready_reg <= 1'b0;
            end
            if (wvalid && wready_reg) begin
                w_got_reg  <= 1'b1;
                wready_reg <= 1'b0;
            end
            // both halves here: commit and answer
            if (wr_fire) begin
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg  <= (wr_sel == mtp_pkg::REG_NONE) ? mtp_pkg::RESP_DECERR : mtp_pkg::RESP_OKAY;
            end
            // reopen only after the response is taken
            if (bvalid_reg && bready) begin
                bvalid_reg  <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    // write payload capture; only the low byte matters
    always_ff @(posedge aclk) begin
        if (awvalid && awready_reg) begin
            awaddr_reg <= awaddr;
        end
        if (wvalid && wready_reg) begin
            wdata_reg  <= wdata[7:0];
            wstrb0_reg <= wstrb[0];
        end
    end

    assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
    assign wr_sel  = mtp_pkg::mtp_decode(awaddr_reg[7:0]);
    assign rd_sel  = mtp_pkg::mtp_decode(araddr[7:0]);

    // control and edge registers; output-reset bit is a strobe, not stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_a_reg        <= mtp_pkg::CTRL_RST;
            ctrl_b_reg        <= mtp_pkg::CTRL_RST;
            ctrl_cd_reg       <= mtp_pkg::CTRL_RST;
            edge_polarity_reg <= mtp_pkg::EDGE_RST;
        end else if (wr_fire && wstrb0_reg) begin
            if (wr_sel == mtp_pkg::REG_CTRL_A) begin
                ctrl_a_reg <= {4'h0, wdata_reg[3:0]};
            end else if (wr_sel == mtp_pkg::REG_CTRL_B) begin
                ctrl_b_reg <= {4'h0, wdata_reg[3:0]};
            end else if (wr_sel == mtp_pkg::REG_CTRL_CD) begin
                ctrl_cd_reg <= {1'b0, wdata_reg[6:4], 1'b0, wdata_reg[2:0]};
            end else if (wr_sel == mtp_pkg::REG_EDGE) begin
                edge_polarity_reg <= wdata_reg;
            end
        end
    end

    // read channel, one cycle answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= mtp_pkg::RESP_OKAY;
        end else if (arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= mtp_pkg::RESP_OKAY;
            // unmapped reads answer decerr with zero data
            if (rd_sel == mtp_pkg::REG_CTRL_A) rdata_reg <= {24'h0, ctrl_a_reg};
            else if (rd_sel == mtp_pkg::REG_CTRL_B) rdata_reg <= {24'h0, ctrl_b_reg};
            else if (rd_sel == mtp_pkg::REG_CTRL_CD) rdata_reg <= {24'h0, ctrl_cd_reg};
            else if (rd_sel == mtp_pkg::REG_DATA_A) rdata_reg <= {24'h0, chan_count[0]};
            else if (rd_sel == mtp_pkg::REG_DATA_B) rdata_reg <= {24'h0, chan_count[1]};
            else if (rd_sel == mtp_pkg::REG_DATA_C) rdata_reg <= {24'h0, chan_count[2]};
            else if (rd_sel == mtp_pkg::REG_DATA_D) rdata_reg <= {24'h0, chan_count[3]};
            else if (rd_sel == mtp_pkg::REG_EDGE) rdata_reg <= {24'h0, edge_polarity_reg};
            else if (rd_sel == mtp_pkg::REG_STATUS) rdata_reg <= {24'h0, filt_reg[2], filt_reg[3], status_reg};
            else begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= mtp_pkg::RESP_DECERR;
            end
        end else if (rvalid_reg && rready) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // three-stage conditioning; a level counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg   <= 4'h0;
            s2_reg   <= 4'h0;
            s3_reg   <= 4'h0;
            filt_reg <= 4'h0;
        end else begin
            s1_reg   <= {io_line_four, io_line_three, aux_input_b, aux_input_a};
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));
        end
    end

    assign chan_mode[0] = ctrl_a_reg[3:0];
    assign chan_mode[1] = ctrl_b_reg[3:0];
    assign chan_mode[2] = {1'b0, ctrl_cd_reg[2:0]};
    localparam int CTRL_D_LSB_I = mtp_pkg::CTRL_D_LSB;
    assign chan_mode[3] = {1'b0, ctrl_cd_reg[CTRL_D_LSB_I +: 3]};
    assign edge_bit = {edge_polarity_reg[mtp_pkg::EDGE_BIT_B], edge_polarity_reg[mtp_pkg::EDGE_BIT_A]};

    // aux input handling for timers a (0) and b (1)
    for (genvar k = 0; k < 2; k++) begin : g_aux
        assign pw_mode[k]  = chan_mode[k][3] && (chan_mode[k][2:0] != 3'h0);
        assign evt_mode[k] = chan_mode[k] == mtp_pkg::MODE_EVENT;
        // active level follows the edge bit; an edge-bit flip can make a count
        assign act[k]      = filt_reg[k] ~^ edge_bit[k];
        // channel four takes aux a, three takes aux b in pulse width mode
        // otherwise the io line itself; the inversion moves the edge to pulse end
        assign chan_lvl[k] = (pw_mode[k] ? filt_reg[k] : filt_reg[3 - k]) ^ pw_mode[k];
        // rising edge of the edge-corrected level; mode changes pass through too
        assign io_event[k] = (chan_lvl[k] ~^ edge_bit[k]) && !chan_prev_reg[k];
        assign force_low[k] = wr_fire && wstrb0_reg && wdata_reg[mtp_pkg::CTRL_OUT_RST_BIT] &&
                              (wr_sel == (k == 0 ? mtp_pkg::REG_CTRL_A : mtp_pkg::REG_CTRL_B));

        // edge history, preset to active by reset
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                act_prev_reg[k]  <= 1'b1;   // filtered levels reset low read as active: no false edge
                chan_prev_reg[k] <= 1'b1;
            end else begin
                act_prev_reg[k]  <= act[k];
                chan_prev_reg[k] <= chan_lvl[k] ~^ edge_bit[k];
            end
        end
    end

    // four timer channels; only a and b get the aux modes
    for (genvar i = 0; i < 4; i++) begin : g_tmr
        assign chan_bus[i].mode        = chan_mode[i];
        assign chan_bus[i].gate        = (i < 2) ? act[i % 2] : 1'b0;
        assign chan_bus[i].event_pulse = (i < 2) ? (evt_mode[i % 2] && act[i % 2] &&
                                                    !act_prev_reg[i % 2]) : 1'b0;
        assign chan_bus[i].data_we     = wr_fire && wstrb0_reg &&
                                         (wr_sel == mtp_pkg::mtp_reg_t'(4'(int'(mtp_pkg::REG_DATA_A) + i)));
        assign chan_bus[i].data_wval   = wdata_reg;
        assign chan_count[i]           = chan_bus[i].count;
        assign timeouts[i]             = chan_bus[i].timeout;

        mtp_timer_chan #(
            .MULTI (i < 2)
        ) u_chan (
            .aclk    (aclk),
            .aresetn (aresetn),
            .bus     (chan_bus[i])
        );
    end

    // timer outputs: low in reset, a and b forced low by the strobe, else toggle on timeout
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_out_reg <= 4'h0;
        end else begin
            for (int j = 0; j < 4; j++) begin
                if (j < 2 && force_low[j % 2]) begin
                    timer_out_reg[j] <= 1'b0;
                end else if (timeouts[j]) begin
                    timer_out_reg[j] <= ~timer_out_reg[j];
                end
            end
        end
    end

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= mtp_pkg::STAT_RST;
        end else begin
            status_reg <= (status_reg & ~((wr_fire && wstrb0_reg && wr_sel == mtp_pkg::REG_STATUS) ?
                           wdata_reg[5:0] : 6'h00)) | {io_event[1], io_event[0], timeouts};
        end
    end

    assign awready   = awready_reg;
    assign wready    = wready_reg;
    assign bvalid    = bvalid_reg;
    assign bresp     = bresp_reg;
    assign arready   = arready_reg;
    assign rvalid    = rvalid_reg;
    assign rdata     = rdata_reg;
    assign rresp     = rresp_reg;
    assign timer_out = timer_out_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // pulse on aux a ends while measuring with active-high polarity
    sequence s_pulse_end_a;
        pw_mode[0] && edge_bit[0] && $stable(ctrl_a_reg) && $stable(edge_polarity_reg) && $fell(filt_reg[0]);
    endsequence

    chk_pulse_end_irq: assert property (s_pulse_end_a |=> status_reg[mtp_pkg::STAT_IO_FOUR])
        else $error("pulse end did not raise channel four");
    chk_out_reset_low: assert property ($rose(aresetn) |-> timer_out == 4'h0)
        else $error("timer outputs not low after reset");
    chk_out_toggle_a: assert property (timeouts[0] && !force_low[0] |=> timer_out[0] != $past(timer_out[0]))
        else $error("timer a output missed a toggle");
    chk_out_force_b: assert property (force_low[1] |=> !timer_out[1])
        else $error("timer b output not forced low");
    chk_event_count_b: assert property (evt_mode[1] && $rose(act[1]) |-> chan_bus[1].event_pulse)
        else $error("event edge gave no count pulse");
    chk_write_answer: assert property (wr_fire |=> bvalid ##0 (bresp == (($past(wr_sel) == mtp_pkg::REG_NONE) ?
        mtp_pkg::RESP_DECERR : mtp_pkg::RESP_OKAY))) else $error("write answer wrong");

endmodule : mtp_timer_top

// ==== verification/mtp_aux_src.sv ====
`timescale 1ns/1ps
// behavioural source of pulses and events on the auxiliary inputs
module mtp_aux_src (
    input  wire logic aclk,
    output logic      aux_a,
    output logic      aux_b,
    output logic      io3,
    output logic      io4
);
    // idle levels at time zero
    initial begin
        aux_a = 1'b0;
        aux_b = 1'b0;
        io3   = 1'b0;
        io4   = 1'b0;
    end
    // rising edges on aux a; six clocks per level, above the two-clock minimum
    task automatic pulses_a(input int n);
        repeat (n) begin
            aux_a <= 1'b1;
            repeat (6) @(posedge aclk);
            aux_a <= 1'b0;
            repeat (6) @(posedge aclk);
        end
    endtask : pulses_a
    // one gate window on aux b, entered just after an edge
    task automatic gate_b(input int len);
        aux_b <= 1'b1;
        repeat (len) @(posedge aclk);
        aux_b <= 1'b0;
    endtask : gate_b
    // static levels on the two general io lines
    task automatic io_level(input logic three, input logic four);
        io3 <= three;
        io4 <= four;
    endtask : io_level
endmodule : mtp_aux_src

// ==== verification/mtp_timer_top_tb.sv ====
`timescale 1ns/1ps
// register-level bench for the multimode timer
module mtp_timer_top_tb;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h1, timer_out;
    logic awready, wready, bvalid, arready, rvalid, aux_a, aux_b, io3, io4;
    logic [1:0] bresp, rresp, br;
    logic [31:0] rd;
    int errors = 0, check_count = 0, n;
    always #5 aclk = ~aclk; // 100 mhz
    mtp_timer_top mtp_timer_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .aux_input_a(aux_a), .aux_input_b(aux_b),
        .io_line_three(io3), .io_line_four(io4), .timer_out(timer_out));
    mtp_aux_src mtp_aux_src_inst (.aclk(aclk), .aux_a(aux_a), .aux_b(aux_b), .io3(io3), .io4(io4));
    // compare and count; unknowns never match
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : chk
    // axi4-lite write, address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        br = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr
    // axi4-lite read; rready held until rvalid is sampled
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] resp, input string name, input logic [31:0] exp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        chk({name, "_resp"}, {30'h0, resp}, {30'h0, rresp});
        if (name != "") chk(name, exp, rd);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd
    // edges until timer a output flips, bounded
    task automatic wait_flip_a(output int cyc);
        logic o;
        o = timer_out[0];
        cyc = 0;
        do begin
            @(posedge aclk);
            cyc++;
        end while (timer_out[0] === o && cyc < 400);
        if (timer_out[0] === o) chk("flip_a_limit", {31'h0, ~o}, {31'h0, o});
    endtask : wait_flip_a
    // counts, verdict and end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // watchdog over a span well beyond the tests
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        give_verdict();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("out_reset", 32'h0, {28'h0, timer_out});
        axi_rd(mtp_pkg::OFF_CTRL_A, mtp_pkg::RESP_OKAY, "ctrl_a_rst", 32'h0);
        axi_rd(8'h24, mtp_pkg::RESP_DECERR, "", 32'h0);
        axi_wr(8'h24, 8'h00);
        chk("bresp_unmapped", {30'h0, mtp_pkg::RESP_DECERR}, {30'h0, br});
        $display("test reset done");
        axi_wr(mtp_pkg::OFF_DATA_A, 8'h03);
        chk("bresp_ok", {30'h0, mtp_pkg::RESP_OKAY}, {30'h0, br});
        axi_wr(mtp_pkg::OFF_CTRL_A, 8'h01);
        wait_flip_a(n);
        wait_flip_a(n);
        chk("period_a", 32'd12, n);
        axi_rd(mtp_pkg::OFF_STATUS, mtp_pkg::RESP_OKAY, "", 32'h0);
        chk("stat_a", 32'h1, {31'h0, rd[0]});
        // align to a fresh toggle so the forced write cannot meet a timeout
        wait_flip_a(n);
        if (timer_out[0] !== 1'b1) wait_flip_a(n);
        axi_wr(mtp_pkg::OFF_CTRL_A, 8'h11);
        chk("out_forced", 32'h0, {31'h0, timer_out[0]});
        wait_flip_a(n);
        chk("out_resume", 32'h1, {31'h0, timer_out[0]});
        axi_rd(mtp_pkg::OFF_CTRL_A, mtp_pkg::RESP_OKAY, "ctrl_a_rd", 32'h01);
        $display("test delay done");
        axi_wr(mtp_pkg::OFF_CTRL_A, 8'h00);
        axi_wr(mtp_pkg::OFF_DATA_A, 8'h05);
        axi_wr(mtp_pkg::OFF_EDGE, 8'h18);
        axi_wr(mtp_pkg::OFF_CTRL_A, {4'h0, mtp_pkg::MODE_EVENT});
        mtp_aux_src_inst.pulses_a(3);
        axi_rd(mtp_pkg::OFF_DATA_A, mtp_pkg::RESP_OKAY, "events_a", 32'h02);
        $display("test event done");
        axi_wr(mtp_pkg::OFF_DATA_B, 8'hc8);
        axi_wr(mtp_pkg::OFF_CTRL_B, 8'h09);
        repeat (40) @(posedge aclk);
        axi_rd(mtp_pkg::OFF_DATA_B, mtp_pkg::RESP_OKAY, "gate_off_b", 32'hc8);
        // drop the event left by entering the mode
        axi_wr(mtp_pkg::OFF_STATUS, 8'h30);
        axi_rd(mtp_pkg::OFF_STATUS, mtp_pkg::RESP_OKAY, "", 32'h0);
        chk("stat_clear", 32'h0, {30'h0, rd[5:4]});
        mtp_aux_src_inst.gate_b(40);
        repeat (8) @(posedge aclk);
        // 40 gated clocks at divide by four: ten count pulses
        axi_rd(mtp_pkg::OFF_DATA_B, mtp_pkg::RESP_OKAY, "gate_on_b", 32'hbe);
        axi_rd(mtp_pkg::OFF_STATUS, mtp_pkg::RESP_OKAY, "", 32'h0);
        chk("pw_end_b", 32'h1, {31'h0, rd[5]});
        $display("test pulse width done");
        axi_wr(mtp_pkg::OFF_STATUS, 8'h30);
        mtp_aux_src_inst.io_level(1'b1, 1'b1);
        repeat (8) @(posedge aclk);
        // both levels visible; only line four is a live channel now
        axi_rd(mtp_pkg::OFF_STATUS, mtp_pkg::RESP_OKAY, "", 32'h0);
        chk("io_lines", 32'hd, {28'h0, rd[7:4]});
        $display("test io lines done");
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("out_rerst", 32'h0, {28'h0, timer_out});
        axi_rd(mtp_pkg::OFF_DATA_A, mtp_pkg::RESP_OKAY, "keep_a", 32'h02);
        axi_rd(mtp_pkg::OFF_DATA_B, mtp_pkg::RESP_OKAY, "keep_b", 32'hbe);
        $display("test reset keep done");
        give_verdict();
    end
endmodule : mtp_timer_top_tb
